//--- inc/dsfc_pkg.sv
/*
  dsfc_pkg: register map, field positions, reset values, limits, modes,
  states and timing constants of the stop sequencer and frequency clamp.
  Assumes a 100 MHz core clock and a 32-bit APB register bus.
*/
package dsfc_pkg;
  localparam int FW     = 16;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FREQ_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LOWEST   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TOP      = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_BASE     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ENTRY    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_OFF_WAIT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_HOLD     = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_STRENGTH = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_DWELL_F  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_DWELL_T  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_STALL    = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_STEP     = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_OUT_FREQ = 8'h38;

  // control fields
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int CTRL_MODE_MSB  = 3;
  localparam int CTRL_REACC_BIT = 4;
  localparam int STALL_DEC_BIT  = 3;
  // status fields
  localparam int STAT_STATE_MSB = 2;
  localparam int STAT_STOP_BIT  = 3;
  localparam int STAT_SKIP_BIT  = 4;
  localparam int STAT_BUS_BIT   = 5;

  // stop modes
  localparam logic [2:0] MODE_DEC   = 3'h0;
  localparam logic [2:0] MODE_DCBRK = 3'h1;
  localparam logic [2:0] MODE_FREE  = 3'h2;
  localparam logic [2:0] MODE_PWR   = 3'h4;
  localparam logic [2:0] MODE_MAX   = 3'h4;

  // reset values and ranges; frequencies in 0.01 Hz, off-wait in 0.01 s, hold in 1 s
  localparam logic [FW-1:0] LOWEST_RST  = 16'h0032; // 0.50 Hz
  localparam logic [FW-1:0] LOWEST_MIN  = 16'h0001; // 0.01 Hz
  localparam logic [FW-1:0] LOWEST_MAX  = 16'h03e8; // 10.00 Hz
  localparam logic [FW-1:0] TOP_RST     = 16'h1770; // 60.00 Hz
  localparam logic [FW-1:0] TOP_MIN     = 16'h0fa0; // 40.00 Hz
  localparam logic [FW-1:0] TOP_MAX     = 16'h9c40; // 400.00 Hz
  localparam logic [FW-1:0] BASE_RST    = 16'h1770; // 60.00 Hz
  localparam logic [FW-1:0] ENTRY_RST   = 16'h01f4; // 5.00 Hz
  localparam logic [FW-1:0] ENTRY_MAX   = 16'h1770; // 60.00 Hz
  localparam logic [FW-1:0] WAIT_RST    = 16'h000a; // 0.10 s
  localparam logic [FW-1:0] WAIT_MAX    = 16'h1770; // 60.00 s
  localparam logic [FW-1:0] HOLD_RST    = 16'h0001; // 1 s
  localparam logic [FW-1:0] HOLD_MAX    = 16'h003c; // 60 s
  localparam logic [7:0]    STREN_RST   = 8'h32;    // 50 %
  localparam logic [7:0]    STREN_MAX   = 8'hc8;    // 200 %
  localparam logic [FW-1:0] STEP_RST    = 16'h0064; // 1.00 Hz per 0.01 s
  localparam logic [FW-1:0] CS_PER_SEC  = 16'h0064; // centiseconds a second

  // timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int CENTISEC_NS     = 10_000_000;
  localparam int CENTISEC_CYCLES = CENTISEC_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RUN    = 3'b001,
    ST_DECEL  = 3'b010,
    ST_BLOCK  = 3'b011,
    ST_INJECT = 3'b100
  } dsfc_state_t;
endpackage : dsfc_pkg

//--- inc/dsfc_clamp_if.sv
/*
  dsfc_clamp_if: carries a commanded frequency and its limits to the
  clamp and the clamped result back. Assumes dsfc_pkg is compiled first.
*/
`timescale 1ns/1ns
interface dsfc_clamp_if;
  logic [dsfc_pkg::FW-1:0] cmd;
  logic [dsfc_pkg::FW-1:0] lowest;
  logic [dsfc_pkg::FW-1:0] top;
  logic [dsfc_pkg::FW-1:0] clamped;
  modport core  (output cmd, output lowest, output top, input clamped);
  modport clamp (input cmd, input lowest, input top, output clamped);
endinterface : dsfc_clamp_if

//--- src/dsfc_freq_clamp.sv
/*
  dsfc_freq_clamp: combinational limit of a commanded frequency: zero below
  the start frequency setting, capped at the maximum frequency setting.
  Assumes limits are already in their legal ranges.
*/
`timescale 1ns/1ns
module dsfc_freq_clamp (
  dsfc_clamp_if.clamp lim
);
  always_comb begin
    if (lim.cmd < lim.lowest) begin
      lim.clamped = '0;
    end else if (lim.cmd > lim.top) begin
      lim.clamped = lim.top;
    end else begin
      lim.clamped = lim.cmd;
    end
  end
endmodule : dsfc_freq_clamp

//--- src/dsfc_stop_seq.sv
/*
  dsfc_stop_seq: stop-mode sequencer with APB registers. Ramps the output
  frequency, sequences ramp, output block, DC injection, coast and power
  braking, and clamps the commanded frequency.
  Assumes one 100 MHz clock, asynchronous reset, and bus-overvoltage and
  stall-limit levels from the power stage, asynchronous to this clock.
*/
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ns
module dsfc_stop_seq #(
  parameter int CENTISEC = dsfc_pkg::CENTISEC_CYCLES
) (
  input  wire logic                          CORE_CLK,
  input  wire logic                          RST,
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [dsfc_pkg::ADDR_W-1:0]   PADDR,
  input  wire logic [31:0]                   PWDATA,
  output logic                               PREADY,
  output logic [31:0]                        PRDATA,
  output logic                               PSLVERR,
  input  wire logic                          BUS_OVER,
  input  wire logic                          STALL_LIMIT,
  output logic [dsfc_pkg::FW-1:0]            OUT_FREQ,
  output logic                               OUT_EN,
  output logic                               DC_INJ_EN,
  output logic [7:0]                         DC_INJ_LEVEL,
  output logic [dsfc_pkg::FW-1:0]            BASE_FREQ,
  output logic                               STOPPED
);
  localparam int FW = dsfc_pkg::FW;

  // pin synchronisers
  logic [1:0] pin_in;
  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;
  logic [1:0] pin_q;
  logic [1:0] next_pin_q;
  assign pin_in = {STALL_LIMIT, BUS_OVER};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_comb begin
        next_pin_q[gi] = (s2[gi] == s3[gi]) ? s3[gi] : pin_q[gi];
      end
      always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
          s1[gi]    <= 1'b0;
          s2[gi]    <= 1'b0;
          s3[gi]    <= 1'b0;
          pin_q[gi] <= 1'b0;
        end else begin
          s1[gi]    <= pin_in[gi];
          s2[gi]    <= s1[gi];
          s3[gi]    <= s2[gi];
          pin_q[gi] <= next_pin_q[gi];
        end
      end
    end
  endgenerate

  logic bus_over;
  logic stall_lim;
  assign bus_over  = pin_q[0];
  assign stall_lim = pin_q[1];

  // registers
  logic          run_cmd;
  logic [2:0]    mode;
  logic          reaccel;
  logic [FW-1:0] freq_cmd;
  logic [FW-1:0] lowest_run_frequency;
  logic [FW-1:0] top_frequency;
  logic [FW-1:0] base_frequency;
  logic [FW-1:0] injection_entry_frequency;
  logic [FW-1:0] output_off_wait;
  logic [FW-1:0] injection_hold_time;
  logic [7:0]    injection_strength;
  logic [FW-1:0] dwell_freq;
  logic [FW-1:0] dwell_time;
  logic [7:0]    stall_prevention_options;
  logic [FW-1:0] ramp_step;
  logic [31:0]   rdata;
  logic          rerr;

  logic          next_run_cmd;
  logic [2:0]    next_mode;
  logic          next_reaccel;
  logic [FW-1:0] next_freq_cmd;
  logic [FW-1:0] next_lowest;
  logic [FW-1:0] next_top;
  logic [FW-1:0] next_base;
  logic [FW-1:0] next_entry;
  logic [FW-1:0] next_wait;
  logic [FW-1:0] next_hold;
  logic [7:0]    next_strength;
  logic [FW-1:0] next_dwell_f;
  logic [FW-1:0] next_dwell_t;
  logic [7:0]    next_stall;
  logic [FW-1:0] next_step;
  logic [31:0]   next_rdata;
  logic          next_rerr;

  // sequencer state
  dsfc_pkg::dsfc_state_t state;
  dsfc_pkg::dsfc_state_t next_state;
  logic [FW-1:0] freq;
  logic [FW-1:0] next_freq;
  logic [FW-1:0] timer;
  logic [FW-1:0] next_timer;
  logic [FW-1:0] dwell_cnt;
  logic [FW-1:0] next_dwell_cnt;
  logic [31:0]   pre;
  logic [31:0]   next_pre;
  logic          stopped;
  logic          next_stopped;

  logic          wr;
  logic          setup;
  logic [FW-1:0] wd;
  logic          tick;
  logic [FW-1:0] target;
  logic          dwell_on;
  logic          dwell_skip;
  logic          in_decel;

  dsfc_clamp_if lim_if ();
  assign lim_if.cmd    = freq_cmd;
  assign lim_if.lowest = lowest_run_frequency;
  assign lim_if.top    = top_frequency;
  assign target        = lim_if.clamped;

  dsfc_freq_clamp u_clamp (
    .lim (lim_if.clamp)
  );

  assign setup  = PSEL && !PENABLE;
  assign wr     = PSEL && PENABLE && PWRITE;
  assign wd     = PWDATA[FW-1:0];
  assign PREADY = PSEL && PENABLE;

  // register writes and read capture
  always_comb begin
    next_run_cmd  = run_cmd;
    next_mode     = mode;
    next_reaccel  = reaccel;
    next_freq_cmd = freq_cmd;
    next_lowest   = lowest_run_frequency;
    next_top      = top_frequency;
    next_base     = base_frequency;
    next_entry    = injection_entry_frequency;
    next_wait     = output_off_wait;
    next_hold     = injection_hold_time;
    next_strength = injection_strength;
    next_dwell_f  = dwell_freq;
    next_dwell_t  = dwell_time;
    next_stall    = stall_prevention_options;
    next_step     = ramp_step;
    next_rdata    = rdata;
    next_rerr     = rerr;
    if (wr) begin
      case (PADDR)
        dsfc_pkg::OFS_CTRL: begin
          next_run_cmd = PWDATA[dsfc_pkg::CTRL_RUN_BIT];
          next_reaccel = PWDATA[dsfc_pkg::CTRL_REACC_BIT];
          if (PWDATA[dsfc_pkg::CTRL_MODE_MSB:dsfc_pkg::CTRL_MODE_LSB]
              <= dsfc_pkg::MODE_MAX) begin
            next_mode = PWDATA[dsfc_pkg::CTRL_MODE_MSB:
                               dsfc_pkg::CTRL_MODE_LSB];
          end
        end
        dsfc_pkg::OFS_FREQ_CMD: next_freq_cmd = wd;
        dsfc_pkg::OFS_LOWEST: begin
          if (wd >= dsfc_pkg::LOWEST_MIN && wd <= dsfc_pkg::LOWEST_MAX)
            next_lowest = wd;
        end
        dsfc_pkg::OFS_TOP: begin
          if (wd >= dsfc_pkg::TOP_MIN && wd <= dsfc_pkg::TOP_MAX)
            next_top = wd;
        end
        dsfc_pkg::OFS_BASE: next_base = wd;
        dsfc_pkg::OFS_ENTRY: begin
          if (wd <= dsfc_pkg::ENTRY_MAX) next_entry = wd;
        end
        dsfc_pkg::OFS_OFF_WAIT: begin
          if (wd <= dsfc_pkg::WAIT_MAX) next_wait = wd;
        end
        dsfc_pkg::OFS_HOLD: begin
          if (wd <= dsfc_pkg::HOLD_MAX) next_hold = wd;
        end
        dsfc_pkg::OFS_STRENGTH: begin
          if (PWDATA[7:0] <= dsfc_pkg::STREN_MAX && PWDATA[31:8] == '0)
            next_strength = PWDATA[7:0];
        end
        dsfc_pkg::OFS_DWELL_F: next_dwell_f = wd;
        dsfc_pkg::OFS_DWELL_T: next_dwell_t = wd;
        dsfc_pkg::OFS_STALL:   next_stall = PWDATA[7:0];
        dsfc_pkg::OFS_STEP:    next_step = wd;
        default: ;
      endcase
    end
    if (setup) begin
      next_rerr  = 1'b0;
      next_rdata = '0;
      case (PADDR)
        dsfc_pkg::OFS_CTRL: begin
          next_rdata[dsfc_pkg::CTRL_RUN_BIT] = run_cmd;
          next_rdata[dsfc_pkg::CTRL_MODE_MSB:dsfc_pkg::CTRL_MODE_LSB] = mode;
          next_rdata[dsfc_pkg::CTRL_REACC_BIT] = reaccel;
        end
        dsfc_pkg::OFS_FREQ_CMD: next_rdata[FW-1:0] = freq_cmd;
        dsfc_pkg::OFS_LOWEST:   next_rdata[FW-1:0] = lowest_run_frequency;
        dsfc_pkg::OFS_TOP:      next_rdata[FW-1:0] = top_frequency;
        dsfc_pkg::OFS_BASE:     next_rdata[FW-1:0] = base_frequency;
        dsfc_pkg::OFS_ENTRY:    next_rdata[FW-1:0] = injection_entry_frequency;
        dsfc_pkg::OFS_OFF_WAIT: next_rdata[FW-1:0] = output_off_wait;
        dsfc_pkg::OFS_HOLD:     next_rdata[FW-1:0] = injection_hold_time;
        dsfc_pkg::OFS_STRENGTH: next_rdata[7:0]    = injection_strength;
        dsfc_pkg::OFS_DWELL_F:  next_rdata[FW-1:0] = dwell_freq;
        dsfc_pkg::OFS_DWELL_T:  next_rdata[FW-1:0] = dwell_time;
        dsfc_pkg::OFS_STALL:    next_rdata[7:0]    = stall_prevention_options;
        dsfc_pkg::OFS_STEP:     next_rdata[FW-1:0] = ramp_step;
        dsfc_pkg::OFS_STATUS: begin
          next_rdata[dsfc_pkg::STAT_STATE_MSB:0] = state;
          next_rdata[dsfc_pkg::STAT_STOP_BIT]    = stopped;
          next_rdata[dsfc_pkg::STAT_SKIP_BIT]    = dwell_skip;
          next_rdata[dsfc_pkg::STAT_BUS_BIT]     = bus_over;
        end
        dsfc_pkg::OFS_OUT_FREQ: next_rdata[FW-1:0] = freq;
        default: next_rerr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      run_cmd                   <= 1'b0;
      mode                      <= dsfc_pkg::MODE_DEC;
      reaccel                   <= 1'b0;
      freq_cmd                  <= '0;
      lowest_run_frequency      <= dsfc_pkg::LOWEST_RST;
      top_frequency             <= dsfc_pkg::TOP_RST;
      base_frequency            <= dsfc_pkg::BASE_RST;
      injection_entry_frequency <= dsfc_pkg::ENTRY_RST;
      output_off_wait           <= dsfc_pkg::WAIT_RST;
      injection_hold_time       <= dsfc_pkg::HOLD_RST;
      injection_strength        <= dsfc_pkg::STREN_RST;
      dwell_freq                <= '0;
      dwell_time                <= '0;
      stall_prevention_options  <= '0;
      ramp_step                 <= dsfc_pkg::STEP_RST;
      rdata                     <= '0;
      rerr                      <= 1'b0;
    end else begin
      run_cmd                   <= next_run_cmd;
      mode                      <= next_mode;
      reaccel                   <= next_reaccel;
      freq_cmd                  <= next_freq_cmd;
      lowest_run_frequency      <= next_lowest;
      top_frequency             <= next_top;
      base_frequency            <= next_base;
      injection_entry_frequency <= next_entry;
      output_off_wait           <= next_wait;
      injection_hold_time       <= next_hold;
      injection_strength        <= next_strength;
      dwell_freq                <= next_dwell_f;
      dwell_time                <= next_dwell_t;
      stall_prevention_options  <= next_stall;
      ramp_step                 <= next_step;
      rdata                     <= next_rdata;
      rerr                      <= next_rerr;
    end
  end

  assign PRDATA  = rdata;
  assign PSLVERR = PSEL && PENABLE && rerr;

  // dwell is skipped when it sits below the injection entry in mode 1
  assign dwell_skip = (mode == dsfc_pkg::MODE_DCBRK) &&
                      (dwell_freq < injection_entry_frequency);
  assign dwell_on   = (dwell_freq != '0) && !dwell_skip;
  assign tick       = (pre == 32'(CENTISEC - 1));
  assign in_decel   = (state == dsfc_pkg::ST_DECEL);

  // sequencer
  always_comb begin
    next_state     = state;
    next_freq      = freq;
    next_timer     = timer;
    next_dwell_cnt = dwell_cnt;
    next_stopped   = stopped;
    case (state)
      dsfc_pkg::ST_IDLE: begin
        next_freq = '0;
        if (run_cmd) begin
          next_state     = dsfc_pkg::ST_RUN;
          next_stopped   = 1'b0;
          next_dwell_cnt = '0;
        end
      end
      dsfc_pkg::ST_RUN: begin
        if (!run_cmd && mode == dsfc_pkg::MODE_FREE) begin
          next_state   = dsfc_pkg::ST_IDLE;
          next_freq    = '0;
          next_stopped = 1'b1;
        end else if (!run_cmd) begin
          next_state = dsfc_pkg::ST_DECEL;
        end else if (tick) begin
          if (freq < target) begin
            next_freq = (target - freq > ramp_step) ? freq + ramp_step
                                                    : target;
          end else if (freq > target) begin
            next_freq = (freq - target > ramp_step) ? freq - ramp_step
                                                    : target;
          end
        end
      end
      dsfc_pkg::ST_DECEL: begin
        if (run_cmd) begin
          next_state = dsfc_pkg::ST_RUN;
        end else if (mode == dsfc_pkg::MODE_DCBRK &&
                     freq <= injection_entry_frequency) begin
          next_state = dsfc_pkg::ST_BLOCK;
          next_freq  = '0;
          next_timer = output_off_wait;
        end else if (freq == '0) begin
          next_state   = dsfc_pkg::ST_IDLE;
          next_stopped = 1'b1;
        end else if (tick) begin
          if (in_decel && mode == dsfc_pkg::MODE_PWR && bus_over) begin
            // power braking overrides stall prevention
            if (reaccel && freq < top_frequency) begin
              next_freq = (top_frequency - freq > ramp_step)
                          ? freq + ramp_step : top_frequency;
            end
          end else if (mode != dsfc_pkg::MODE_PWR && stall_lim &&
                       stall_prevention_options[dsfc_pkg::STALL_DEC_BIT])
          begin
            next_freq = freq;
          end else if (dwell_on && freq == dwell_freq &&
                       dwell_cnt < dwell_time) begin
            next_dwell_cnt = dwell_cnt + 16'h0001;
          end else if (dwell_on && freq > dwell_freq &&
                       freq - dwell_freq < ramp_step) begin
            next_freq = dwell_freq;
          end else begin
            next_freq = (freq > ramp_step) ? freq - ramp_step : '0;
          end
        end
      end
      dsfc_pkg::ST_BLOCK: begin
        if (timer == '0) begin
          next_state = dsfc_pkg::ST_INJECT;
          next_timer = 16'(injection_hold_time * dsfc_pkg::CS_PER_SEC);
        end else if (tick) begin
          next_timer = timer - 16'h0001;
        end
      end
      dsfc_pkg::ST_INJECT: begin
        if (timer == '0) begin
          next_state   = dsfc_pkg::ST_IDLE;
          next_stopped = 1'b1;
        end else if (tick) begin
          next_timer = timer - 16'h0001;
        end
      end
      default: begin
        next_state = dsfc_pkg::ST_IDLE;
        next_freq  = '0;
      end
    endcase
    // prescaler restarts at each phase entry so phase times are whole
    if (next_state != state || tick) begin
      next_pre = '0;
    end else begin
      next_pre = pre + 32'h1;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state     <= dsfc_pkg::ST_IDLE;
      freq      <= '0;
      timer     <= '0;
      dwell_cnt <= '0;
      pre       <= '0;
      stopped   <= 1'b1;
    end else begin
      state     <= next_state;
      freq      <= next_freq;
      timer     <= next_timer;
      dwell_cnt <= next_dwell_cnt;
      pre       <= next_pre;
      stopped   <= next_stopped;
    end
  end

  // outputs
  logic          out_en;
  logic          inj_en;
  logic [7:0]    inj_level;
  logic          next_out_en;
  logic          next_inj_en;
  logic [7:0]    next_inj_level;

  always_comb begin
    next_out_en    = (next_state == dsfc_pkg::ST_RUN) ||
                     (next_state == dsfc_pkg::ST_DECEL);
    next_inj_en    = (next_state == dsfc_pkg::ST_INJECT);
    next_inj_level = next_inj_en ? injection_strength : 8'h00;
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      out_en    <= 1'b0;
      inj_en    <= 1'b0;
      inj_level <= '0;
    end else begin
      out_en    <= next_out_en;
      inj_en    <= next_inj_en;
      inj_level <= next_inj_level;
    end
  end

  assign OUT_FREQ     = freq;
  assign OUT_EN       = out_en;
  assign DC_INJ_EN    = inj_en;
  assign DC_INJ_LEVEL = inj_level;
  assign BASE_FREQ    = base_frequency;
  assign STOPPED      = stopped;
endmodule : dsfc_stop_seq

//--- tb/dsfc_props.sv
/*
  dsfc_props: port assertions for dsfc_stop_seq, bound to every instance.
  Assumes the default off-wait and hold settings stay in force.
*/
`timescale 1ns/1ns
module dsfc_props (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [15:0] OUT_FREQ,
  input wire logic        OUT_EN,
  input wire logic        DC_INJ_EN,
  input wire logic [7:0]  DC_INJ_LEVEL,
  input wire logic        STOPPED
);
  logic [7:0] off_cnt;
  logic [7:0] next_off_cnt;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence inj_start;
    $rose(DC_INJ_EN);
  endsequence
  always_comb begin
    next_off_cnt = 8'h00;
    if (!OUT_EN && !DC_INJ_EN && !STOPPED) begin
      next_off_cnt = (off_cnt == 8'hff) ? off_cnt : off_cnt + 8'h01;
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) off_cnt <= 8'h00;
    else off_cnt <= next_off_cnt;
  end
  ready_now_a: assert property (PREADY == (PSEL && PENABLE))
    else $error("ready outside access");
  err_access_a: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error outside access");
  idle_zero_a: assert property (!OUT_EN |-> OUT_FREQ == 16'h0000)
    else $error("frequency while output off");
  inj_blocked_a: assert property (DC_INJ_EN |-> !OUT_EN && !STOPPED)
    else $error("injection with output on");
  level_idle_a: assert property (!DC_INJ_EN |-> DC_INJ_LEVEL == 8'h00)
    else $error("level without injection");
  stop_quiet_a: assert property (STOPPED |-> !OUT_EN && !DC_INJ_EN)
    else $error("stopped yet driving");
  inj_end_a: assert property ($fell(DC_INJ_EN) |-> STOPPED)
    else $error("injection end not stopped");
  block_first_a: assert property (inj_start |-> off_cnt >= 8'h28)
    else $error("block time too short");
  inj_hold_a: assert property (inj_start |-> DC_INJ_EN [*8])
    else $error("injection cut short");
  top_bound_a: assert property (OUT_FREQ <= 16'h9c40)
    else $error("frequency above ceiling");
endmodule : dsfc_props
bind dsfc_stop_seq dsfc_props dsfc_props_inst (.CORE_CLK(CORE_CLK),
  .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .OUT_FREQ(OUT_FREQ), .OUT_EN(OUT_EN),
  .DC_INJ_EN(DC_INJ_EN), .DC_INJ_LEVEL(DC_INJ_LEVEL), .STOPPED(STOPPED));

//--- tb/dsfc_stage_model.sv
/*
  dsfc_stage_model: power stage stand-in raising bus overvoltage and
  stall demands while the output runs. Assumes the sequencer's clock.
*/
`timescale 1ns/1ns
module dsfc_stage_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic out_en,
  input  wire logic regen_req,
  input  wire logic stall_req,
  output logic      bus_over,
  output logic      stall_limit
);
  logic next_bus_over;
  logic next_stall;
  always_comb begin
    next_bus_over = regen_req && out_en;
    next_stall    = stall_req && out_en;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) bus_over <= 1'b0;
    else bus_over <= next_bus_over;
    if (rst) stall_limit <= 1'b0;
    else stall_limit <= next_stall;
  end
endmodule : dsfc_stage_model

//--- tb/tb_top.sv
/*
  tb_top: APB-driven checks of the stop sequencer and frequency clamp.
  Assumes CENTISEC of 4 and the stage model on the far side.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  localparam logic [7:0] RA [9] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
    8'h1c, 8'h20, 8'h30, 8'h34};
  localparam logic [15:0] RV [9] = '{16'h32, 16'h1770, 16'h1770, 16'h1f4,
    16'ha, 16'h1, 16'h32, 16'h64, 16'h8};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr, bus_over, stall_limit, out_en, dc_en, err;
  logic        stopped, regen = 1'b0, stall = 1'b0, inj_seen = 1'b0;
  logic [15:0] out_freq, base_freq, a;
  logic [7:0]  dc_level;
  int          bad_count = 0;
  int          compares = 0;
  int          n;
  always #5 clk = ~clk;
  always @(posedge clk) if (dc_en === 1'b1) inj_seen <= 1'b1;
  dsfc_stop_seq #(.CENTISEC(4)) dsfc_stop_seq_inst (.CORE_CLK(clk),
    .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .BUS_OVER(bus_over), .STALL_LIMIT(stall_limit),
    .OUT_FREQ(out_freq), .OUT_EN(out_en), .DC_INJ_EN(dc_en),
    .DC_INJ_LEVEL(dc_level), .BASE_FREQ(base_freq), .STOPPED(stopped));
  dsfc_stage_model dsfc_stage_model_inst (.clk(clk), .rst(rst),
    .out_en(out_en), .regen_req(regen), .stall_req(stall),
    .bus_over(bus_over), .stall_limit(stall_limit));
  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick
  task wait_freq(input logic [15:0] f);
    for (n = 0; n < 3000 && out_freq !== f; n++) tick(1);
    `CHK(out_freq, f)
  endtask : wait_freq
  task test_done;
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, RA[i], 32'h0);
      `CHK(rdata[15:0], RV[i])
    end
    `CHK(base_freq, 16'h1770)
    apb(1'b0, 8'h3c, 32'h0);
    `CHK({err, rdata}, {1'b1, 32'h0})
    apb(1'b1, 8'h04, 32'h31);
    apb(1'b1, 8'h00, 32'h1);
    tick(40);
    `CHK(out_freq, 16'h0)
    apb(1'b1, 8'h04, 32'h32);
    wait_freq(16'h32);
    apb(1'b1, 8'h04, 32'hffff);
    wait_freq(16'h1770);
    apb(1'b1, 8'h0c, 32'h0f9f);
    apb(1'b0, 8'h0c, 32'h0);
    `CHK(rdata[15:0], 16'h1770)
    apb(1'b1, 8'h04, 32'h3e8);
    for (int m = 0; m < 4; m += 3) begin
      apb(1'b1, 8'h00, 32'(m * 2 + 1));
      wait_freq(16'h3e8);
      apb(1'b1, 8'h00, 32'(m * 2));
      for (n = 0; n < 3000 && stopped !== 1'b1; n++) tick(1);
      `CHK({stopped, out_freq, inj_seen}, {1'b1, 17'h0})
    end
    apb(1'b1, 8'h00, 32'h5);
    wait_freq(16'h3e8);
    apb(1'b1, 8'h00, 32'h4);
    tick(1);
    `CHK({out_en, out_freq}, 17'h0)
    apb(1'b1, 8'h00, 32'ha);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rdata[3:1], 3'h2)
    apb(1'b1, 8'h24, 32'h190);
    apb(1'b1, 8'h20, 32'h64);
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b0, 8'h34, 32'h0);
    `CHK(rdata[5:0], 6'h11)
    wait_freq(16'h3e8);
    apb(1'b1, 8'h00, 32'h2);
    for (n = 0; n < 3000 && out_en !== 1'b0; n++) tick(1);
    for (a = 0; a < 3000 && dc_en !== 1'b1; a++) tick(1);
    `CHK(a, 16'h0029)
    `CHK(dc_level, 8'h64)
    for (a = 0; a < 3000 && dc_en === 1'b1; a++) tick(1);
    `CHK({a, stopped}, {16'h0191, 1'b1})
    apb(1'b1, 8'h00, 32'h9);
    wait_freq(16'h3e8);
    apb(1'b1, 8'h2c, 32'h8);
    stall <= 1'b1;
    regen <= 1'b1;
    apb(1'b1, 8'h00, 32'h8);
    tick(10);
    a = out_freq;
    tick(40);
    `CHK(out_freq, a)
    apb(1'b1, 8'h00, 32'h18);
    tick(40);
    `CHK(out_freq > a, 1'b1)
    regen <= 1'b0;
    for (n = 0; n < 3000 && stopped !== 1'b1; n++) tick(1);
    `CHK({stopped, out_freq}, {1'b1, 16'h0})
    apb(1'b1, 8'h00, 32'h1);
    wait_freq(16'h3e8);
    apb(1'b1, 8'h00, 32'h0);
    tick(40);
    `CHK(out_freq, 16'h3e8)
    stall <= 1'b0;
    for (n = 0; n < 3000 && stopped !== 1'b1; n++) tick(1);
    `CHK({stopped, out_freq}, {1'b1, 16'h0})
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule : tb_top
